// File: rtl/dmacc_core.sv
// four-channel dma control: registers, request sampling, arbitration, counting
// assumes an outside bus sequencer that runs each unit and pulses i_xfer_done
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module dmacc_core
    import dmacc_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_standby,
    input  wire dmacc_bus_t        i_bus,
    output logic [31:0]            o_rdata,
    input  wire logic [1:0]        i_xfer_req_n,
    input  wire logic [NPER-1:0]   i_periph_req,
    input  wire logic              i_nmi,
    input  wire logic              i_addr_err,
    output dmacc_xfer_t            o_xfer,
    output logic                   o_xfer_valid,
    input  wire logic              i_xfer_done,
    output logic [1:0]             o_ack,
    output logic [NCH-1:0]         o_end_irq
);

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_GAP} dmacc_state_t;

    logic [31:0]       ctrl_ff [NCH];
    logic [31:0]       src_ff  [NCH];
    logic [31:0]       dst_ff  [NCH];
    logic [CNT_W-1:0]  cnt_ff  [NCH];
    logic [NCH-1:0]    te_seen_ff;
    logic [NCH-1:0]    pend_ff;
    logic              me_ff;
    logic              nmi_flag_ff;
    logic              ae_ff;
    logic              nmi_flag_seen_ff;
    logic              ae_seen_ff;
    logic [1:0]        pin_d_ff;
    logic [NPER-1:0]   per_d_ff;
    dmacc_state_t      state_ff;
    logic [1:0]        cur_ff;
    logic              own_vld_ff;
    logic [1:0]        own_ff;
    dmacc_xfer_t       xfer_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        ack_ff;
    logic [NCH-1:0]    irq_ff;

    logic [NCH-1:0]    ch_en;
    logic [NCH-1:0]    req;
    logic [NCH-1:0]    edge_ev;
    logic              ch_sel;
    logic [1:0]        ch_idx;
    logic [3:0]        reg_idx;
    logic              wr_glb;
    logic              rd_glb;
    logic              unit_done;
    logic              abort;
    logic              last_unit;
    logic              pick_vld;
    logic [1:0]        pick;

    assign ch_sel  = i_bus.addr[7:6] == CH_AREA;
    assign ch_idx  = i_bus.addr[5:4];
    assign reg_idx = i_bus.addr[3:0];
    assign wr_glb  = i_bus.we && i_bus.addr == OFS_GLOBAL;
    assign rd_glb  = i_bus.re && i_bus.addr == OFS_GLOBAL;

    function automatic logic [31:0] step_addr(input logic [31:0] a,
                                              input logic [1:0]  mode,
                                              input logic [1:0]  sz);
        logic [31:0] inc;
        inc = 32'h0000_0001 << sz;
        if (mode == STEP_INC)
            step_addr = a + inc;
        else if (mode == STEP_DEC)
            step_addr = a - inc;
        else
            step_addr = a;
    endfunction

    function automatic logic [31:0] wmask(input int ch);
        wmask = CTL_WMASK;
        if (ch < 2)
            wmask = wmask | CTL_WM01;
        if (ch == 3)
            wmask = wmask | CTL_WM3;
    endfunction

    // per-channel enable and request view
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            logic [3:0] rs;
            rs = ctrl_ff[i][CTL_RS+:4];
            ch_en[i] = ctrl_ff[i][CTL_DE] && me_ff && !ctrl_ff[i][CTL_TE]
                       && !nmi_flag_ff && !ae_ff;
            edge_ev[i] = 1'b0;
            req[i] = 1'b0;
            if (rs == RS_AUTO)
                req[i] = 1'b1;
            else if (rs >= RS_PER_FIRST)
            begin
                edge_ev[i] = i_periph_req[rs - RS_PER_FIRST]
                             && !per_d_ff[rs - RS_PER_FIRST];
                req[i] = pend_ff[i];
            end
            else if ((rs == RS_EXT_DUAL || rs == RS_EXT_M2D || rs == RS_EXT_D2M)
                     && i < 2)
            begin
                edge_ev[i] = pin_d_ff[i] && !i_xfer_req_n[i];
                if (ctrl_ff[i][CTL_DS])
                    req[i] = pend_ff[i];
                else
                    req[i] = !i_xfer_req_n[i];
            end
            req[i] = req[i] && ch_en[i];
        end
    end

    // lowest channel wins; a burst owner keeps the bus while it still asks
    always_comb
    begin
        pick_vld = |req;
        pick     = 2'h0;
        for (int i = NCH - 1; i >= 0; i--)
            if (req[i])
                pick = 2'(i);
        if (own_vld_ff && req[own_ff])
            pick = own_ff;
    end

    assign abort     = state_ff == ST_XFER && !ch_en[cur_ff];
    assign unit_done = state_ff == ST_XFER && !abort && i_xfer_done;
    assign last_unit = cnt_ff[cur_ff] == CNT_W'(1);

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_d_ff <= 2'h3;
            per_d_ff <= '0;
        end
        else
        begin
            pin_d_ff <= i_xfer_req_n;
            per_d_ff <= i_periph_req;
        end
    end

    // latched edge requests; only those seen while enabled count
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pend_ff <= '0;
        else
            for (int i = 0; i < NCH; i++)
                if (i_standby || !ch_en[i])
                    pend_ff[i] <= 1'b0;
                else if (edge_ev[i])
                    pend_ff[i] <= 1'b1;
                else if (unit_done && cur_ff == 2'(i))
                    pend_ff[i] <= 1'b0;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff   <= ST_IDLE;
            cur_ff     <= 2'h0;
            own_vld_ff <= 1'b0;
            own_ff     <= 2'h0;
            xfer_ff    <= '0;
        end
        else if (i_standby)
        begin
            state_ff   <= ST_IDLE;
            own_vld_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (pick_vld)
                    begin
                        logic [31:0] c;
                        c = ctrl_ff[pick];
                        state_ff         <= ST_XFER;
                        cur_ff           <= pick;
                        xfer_ff.ch       <= pick;
                        xfer_ff.src      <= src_ff[pick];
                        xfer_ff.dst      <= dst_ff[pick];
                        xfer_ff.size     <= c[CTL_TS+:2];
                        xfer_ff.single   <= c[CTL_RS+:4] == RS_EXT_M2D
                                            || c[CTL_RS+:4] == RS_EXT_D2M;
                        xfer_ff.dev2mem  <= c[CTL_RS+:4] == RS_EXT_D2M;
                        xfer_ff.burst    <= c[CTL_TM];
                        xfer_ff.indirect <= pick == 2'h3 && c[CTL_DI];
                    end
                    else
                        own_vld_ff <= 1'b0;
                ST_XFER:
                    if (abort)
                    begin
                        state_ff   <= ST_IDLE;
                        own_vld_ff <= 1'b0;
                    end
                    else if (unit_done)
                    begin
                        // cycle steal hands the bus back for two cycles (ST_GAP, then ST_IDLE)
                        own_vld_ff <= xfer_ff.burst && !last_unit;
                        own_ff     <= cur_ff;
                        state_ff   <= xfer_ff.burst ? ST_IDLE : ST_GAP;
                    end
                ST_GAP:
                    state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // address and count registers; a software write beats the stepping
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            for (int i = 0; i < NCH; i++)
            begin
                src_ff[i] <= '0;
                dst_ff[i] <= '0;
                cnt_ff[i] <= '0;
            end
        else
            for (int i = 0; i < NCH; i++)
            begin
                logic       fixed;
                logic [1:0] ssz;
                fixed = ctrl_ff[i][CTL_RS+:4] == RS_EXT_D2M;
                ssz   = (i == 3 && ctrl_ff[i][CTL_DI]) ? SZ_LONG
                        : ctrl_ff[i][CTL_TS+:2];
                if (i_bus.we && ch_sel && ch_idx == 2'(i) && reg_idx == OFS_SRC)
                    src_ff[i] <= i_bus.wdata;
                else if (unit_done && cur_ff == 2'(i) && !fixed)
                    src_ff[i] <= step_addr(src_ff[i], ctrl_ff[i][CTL_SM+:2], ssz);
                if (i_bus.we && ch_sel && ch_idx == 2'(i) && reg_idx == OFS_DST)
                    dst_ff[i] <= i_bus.wdata;
                else if (unit_done && cur_ff == 2'(i) && !fixed)
                    dst_ff[i] <= step_addr(dst_ff[i], ctrl_ff[i][CTL_DM+:2],
                                           ctrl_ff[i][CTL_TS+:2]);
                if (i_bus.we && ch_sel && ch_idx == 2'(i) && reg_idx == OFS_CNT)
                    cnt_ff[i] <= i_bus.wdata[CNT_W-1:0];
                else if (unit_done && cur_ff == 2'(i))
                    cnt_ff[i] <= cnt_ff[i] - CNT_W'(1);
            end
    end

    // channel_control; the end flag set wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < NCH; i++)
                ctrl_ff[i] <= CTL_RST;
            te_seen_ff <= '0;
        end
        else if (i_standby)
        begin
            for (int i = 0; i < NCH; i++)
                ctrl_ff[i] <= CTL_RST;
            te_seen_ff <= '0;
        end
        else
            for (int i = 0; i < NCH; i++)
            begin
                logic hit_w;
                logic hit_r;
                logic te_set;
                hit_w  = i_bus.we && ch_sel && ch_idx == 2'(i) && reg_idx == OFS_CTRL;
                hit_r  = i_bus.re && ch_sel && ch_idx == 2'(i) && reg_idx == OFS_CTRL;
                te_set = unit_done && cur_ff == 2'(i) && last_unit;
                if (hit_w)
                begin
                    ctrl_ff[i] <= (i_bus.wdata & wmask(i))
                                  | (ctrl_ff[i] & ~wmask(i));
                    ctrl_ff[i][CTL_TE] <= te_set || (ctrl_ff[i][CTL_TE]
                                          && !(te_seen_ff[i] && !i_bus.wdata[CTL_TE]));
                    te_seen_ff[i] <= 1'b0;
                end
                else
                begin
                    if (te_set)
                        ctrl_ff[i][CTL_TE] <= 1'b1;
                    if (hit_r && ctrl_ff[i][CTL_TE])
                        te_seen_ff[i] <= 1'b1;
                end
            end
    end

    // global_operation_control: master enable, nmi and address error flags
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            me_ff        <= 1'b0;
            nmi_flag_ff      <= 1'b0;
            ae_ff        <= 1'b0;
            nmi_flag_seen_ff <= 1'b0;
            ae_seen_ff   <= 1'b0;
        end
        else if (i_standby)
        begin
            me_ff        <= 1'b0;
            nmi_flag_ff      <= 1'b0;
            ae_ff        <= 1'b0;
            nmi_flag_seen_ff <= 1'b0;
            ae_seen_ff   <= 1'b0;
        end
        else
        begin
            if (wr_glb)
            begin
                me_ff        <= i_bus.wdata[GLB_ME];
                nmi_flag_seen_ff <= 1'b0;
                ae_seen_ff   <= 1'b0;
            end
            else
            begin
                if (rd_glb && nmi_flag_ff)
                    nmi_flag_seen_ff <= 1'b1;
                if (rd_glb && ae_ff)
                    ae_seen_ff <= 1'b1;
            end
            if (i_nmi)
                nmi_flag_ff <= 1'b1;
            else if (wr_glb && nmi_flag_seen_ff && !i_bus.wdata[GLB_NMI_FLAG])
                nmi_flag_ff <= 1'b0;
            if (i_addr_err)
                ae_ff <= 1'b1;
            else if (wr_glb && ae_seen_ff && !i_bus.wdata[GLB_AE])
                ae_ff <= 1'b0;
        end
    end

    // read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_ff <= '0;
        else if (rd_glb)
            rdata_ff <= {29'h0, ae_ff, nmi_flag_ff, me_ff};
        else if (i_bus.re && ch_sel)
            unique case (reg_idx)
                OFS_SRC:  rdata_ff <= src_ff[ch_idx];
                OFS_DST:  rdata_ff <= dst_ff[ch_idx];
                OFS_CNT:  rdata_ff <= {8'h00, cnt_ff[ch_idx]};
                OFS_CTRL: rdata_ff <= ctrl_ff[ch_idx];
                default:  rdata_ff <= '0;
            endcase
        else
            rdata_ff <= '0;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ack_ff <= 2'h0;
            irq_ff <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
                ack_ff[i] <= (state_ff == ST_XFER && !abort && cur_ff == 2'(i))
                             ^ ctrl_ff[i][CTL_AL];
            for (int i = 0; i < NCH; i++)
                irq_ff[i] <= ctrl_ff[i][CTL_TE] && ctrl_ff[i][CTL_IE];
        end
    end

    assign o_rdata      = rdata_ff;
    assign o_xfer       = xfer_ff;
    assign o_xfer_valid = state_ff == ST_XFER && !abort;
    assign o_ack        = ack_ff;
    assign o_end_irq    = irq_ff;

endmodule

// File: pkg/dmacc_pkg.sv
// constants, field positions and carrier types of the dma channel control
// assumes one 100 MHz clock; byte addresses on an 8-bit register port
package dmacc_pkg;

    localparam int          NCH        = 4;
    localparam int          CNT_W      = 24;
    localparam int          NPER       = 10;

    // per channel block of four words, channel n at n * 16
    localparam logic [1:0]  CH_AREA    = 2'h0;
    localparam logic [3:0]  OFS_SRC    = 4'h0;
    localparam logic [3:0]  OFS_DST    = 4'h4;
    localparam logic [3:0]  OFS_CNT    = 4'h8;
    localparam logic [3:0]  OFS_CTRL   = 4'hC;
    localparam logic [7:0]  OFS_GLOBAL = 8'h40;

    // channel_control fields
    localparam int          CTL_DI     = 20;
    localparam int          CTL_AL     = 16;
    localparam int          CTL_DM     = 14;
    localparam int          CTL_SM     = 12;
    localparam int          CTL_RS     = 8;
    localparam int          CTL_DS     = 6;
    localparam int          CTL_TM     = 5;
    localparam int          CTL_TS     = 3;
    localparam int          CTL_IE     = 2;
    localparam int          CTL_TE     = 1;
    localparam int          CTL_DE     = 0;
    localparam logic [31:0] CTL_RST    = 32'h0000_0000;
    localparam logic [31:0] CTL_WMASK  = 32'h0000_FF3D;
    localparam logic [31:0] CTL_WM01   = 32'h0001_0040;
    localparam logic [31:0] CTL_WM3    = 32'h0010_0000;

    // global_operation_control fields
    localparam int          GLB_AE     = 2;
    localparam int          GLB_NMI_FLAG   = 1;
    localparam int          GLB_ME     = 0;

    localparam logic [3:0]  RS_EXT_DUAL  = 4'h0;
    localparam logic [3:0]  RS_EXT_M2D   = 4'h2;
    localparam logic [3:0]  RS_EXT_D2M   = 4'h3;
    localparam logic [3:0]  RS_AUTO      = 4'h4;
    localparam logic [3:0]  RS_PER_FIRST = 4'h6;

    localparam logic [1:0]  STEP_INC   = 2'h1;
    localparam logic [1:0]  STEP_DEC   = 2'h2;
    localparam logic [1:0]  SZ_LONG    = 2'h2;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } dmacc_bus_t;

    typedef struct packed {
        logic [1:0]  ch;
        logic [31:0] src;
        logic [31:0] dst;
        logic [1:0]  size;
        logic        single;
        logic        dev2mem;
        logic        burst;
        logic        indirect;
    } dmacc_xfer_t;

endpackage

// File: verif/dmacc_seq_model.sv
// bus sequencer stand-in: finishes each unit a set number of cycles after it appears
// assumes the core holds o_xfer_valid up until the done pulse is taken
`timescale 1ns/1ps
module dmacc_seq_model
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_valid,
    input  wire logic [3:0] i_lat,
    output logic            o_done,
    output int              o_units
);
    logic       fire;
    logic [3:0] wait_ff;

    // a dropped unit restarts the wait, so aborts never see a late done
    assign fire = i_valid && !o_done && (wait_ff >= i_lat);

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_ff <= 4'h0;
            o_done  <= 1'b0;
            o_units <= 0;
        end
        else
        begin
            o_done  <= fire;
            o_units <= o_units + int'(fire);
            wait_ff <= (i_valid && !o_done) ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// File: verif/dmacc_core_sva.sv
// port assertions of the dma channel control core
// assumes one clock domain and the register map of dmacc_pkg
`timescale 1ns/1ps
module dmacc_core_sva
    import dmacc_pkg::*;
(
    input wire logic           i_ref_clk,
    input wire logic           i_rst_n,
    input wire logic           i_standby,
    input wire dmacc_bus_t     i_bus,
    input wire logic           i_nmi,
    input wire logic           i_addr_err,
    input wire dmacc_xfer_t    o_xfer,
    input wire logic           o_xfer_valid,
    input wire logic           i_xfer_done,
    input wire logic [NCH-1:0] o_end_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_nmi_stop;
        i_nmi |=> !o_xfer_valid [*3];
    endproperty
    a_nmi_stop: assert property (p_nmi_stop)
        else $error("unit still offered after nmi");

    property p_aerr_stop;
        i_addr_err |=> !o_xfer_valid [*3];
    endproperty
    a_aerr_stop: assert property (p_aerr_stop)
        else $error("unit still offered after address error");

    property p_master_off;
        i_bus.we && i_bus.addr == OFS_GLOBAL && !i_bus.wdata[GLB_ME] |=> !o_xfer_valid [*2];
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("unit offered with master enable cleared");

    property p_chan_off;
        o_xfer_valid && i_bus.we && i_bus.addr == {CH_AREA, o_xfer.ch, OFS_CTRL}
            && !i_bus.wdata[CTL_DE] |=> !o_xfer_valid;
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("unit kept after channel disable");

    property p_steal_gap;
        o_xfer_valid && i_xfer_done && !o_xfer.burst |=> !o_xfer_valid ##1 !o_xfer_valid;
    endproperty
    a_steal_gap: assert property (p_steal_gap)
        else $error("cycle steal gap missing");

    property p_end_idle;
        o_xfer_valid |-> !o_end_irq[o_xfer.ch];
    endproperty
    a_end_idle: assert property (p_end_idle)
        else $error("unit offered on a finished channel");

    property p_irq_hold;
        !i_bus.we && !i_standby |-> ##2 (o_end_irq & $past(o_end_irq)) == $past(o_end_irq);
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("end interrupt dropped without a write");

    property p_xfer_hold;
        o_xfer_valid && $past(o_xfer_valid) |-> $stable(o_xfer);
    endproperty
    a_xfer_hold: assert property (p_xfer_hold)
        else $error("unit changed while outstanding");
endmodule

bind dmacc_core dmacc_core_sva i_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_standby(i_standby), .i_bus(i_bus), .i_nmi(i_nmi), .i_addr_err(i_addr_err),
    .o_xfer(o_xfer), .o_xfer_valid(o_xfer_valid), .i_xfer_done(i_xfer_done),
    .o_end_irq(o_end_irq));

// File: verif/tb_dmacc_core.sv
// directed tests of the dma channel control core over its register port
// assumes the sequencer model answers units and the checker is bound to the core
`timescale 1ns/1ps
module tb_dmacc_core
    import dmacc_pkg::*;
;
    logic            i_ref_clk = 1'b0;
    logic            i_rst_n   = 1'b0;
    logic            stby      = 1'b0;
    dmacc_bus_t      bus       = '0;
    logic [1:0]      req_n     = 2'b11;
    logic [NPER-1:0] preq      = '0;
    logic            nmi       = 1'b0;
    logic            aerr      = 1'b0;
    logic [3:0]      lat       = 4'h3;
    logic [31:0]     rdata;
    dmacc_xfer_t     xfer;
    logic            valid;
    logic            done;
    logic [1:0]      ack;
    logic [NCH-1:0]  irq;
    int              units;
    int              mark;
    int              failures     = 0;
    int              total_checks = 0;
    logic [31:0]     v;
    logic [31:0]     wexp [NCH] = '{32'h0001_FF7C, 32'h0001_FF7C, 32'h0000_FF3C, 32'h0010_FF3C};
    logic [31:0]     gexp [3]   = '{32'h1, 32'h3, 32'h5};

    always #5 i_ref_clk = ~i_ref_clk;

    dmacc_core i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_standby(stby), .i_bus(bus),
        .o_rdata(rdata), .i_xfer_req_n(req_n), .i_periph_req(preq), .i_nmi(nmi),
        .i_addr_err(aerr), .o_xfer(xfer), .o_xfer_valid(valid), .i_xfer_done(done),
        .o_ack(ack), .o_end_irq(irq));

    dmacc_seq_model i_seq (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_valid(valid),
        .i_lat(lat), .o_done(done), .o_units(units));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one idle cycle after each access keeps strobes from being reassigned in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_ref_clk);
        bus <= '0;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge i_ref_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge i_ref_clk);
    endtask

    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [3:0] ofs);
        return {CH_AREA, ch, ofs};
    endfunction

    function automatic logic [31:0] cw(input logic [1:0] dm, input logic [1:0] sm,
        input logic [3:0] rs, input logic [1:0] ts, input logic tm, input logic ie);
        return {16'h0, dm, sm, rs, 2'b00, tm, ts, ie, 2'b01};
    endfunction

    function automatic logic [31:0] dlt(input logic [1:0] m, input logic [1:0] sz);
        logic [31:0] st;
        st = 32'h1 << sz;
        return (m == 2'h1) ? st : (m == 2'h2) ? -st : 32'h0;
    endfunction

    task automatic setup(input logic [1:0] ch, input logic [31:0] s, input logic [31:0] d,
        input logic [31:0] c, input logic [31:0] ctl);
        mark = units;
        wr(ra(ch, OFS_SRC), s);
        wr(ra(ch, OFS_DST), d);
        wr(ra(ch, OFS_CNT), c);
        wr(ra(ch, OFS_CTRL), ctl);
        wr(OFS_GLOBAL, 32'h1);
    endtask

    task automatic waitu(input int n);
        for (int k = 0; k < 300 && units < mark + n; k++)
            @(posedge i_ref_clk);
        repeat (3) @(posedge i_ref_clk);
        chk(32'(units - mark), 32'(n));
    endtask

    task automatic waitv();
        logic ok = 1'b0;
        for (int k = 0; k < 60 && !ok; k++)
        begin
            @(posedge i_ref_clk);
            #1 ok = valid;
        end
        chk(32'(ok), 32'h1);
    endtask

    task automatic clr(input logic [1:0] ch);
        rd(ra(ch, OFS_CTRL), v);
        wr(ra(ch, OFS_CTRL), 32'h0);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        rd(8'h50, v);
        chk(v, 32'h0);
        for (int c = 0; c < NCH; c++)
        begin
            rd(ra(2'(c), OFS_CTRL), v);
            chk(v, 32'h0);
            wr(ra(2'(c), OFS_CTRL), 32'hFFFF_FFFE);
            rd(ra(2'(c), OFS_CTRL), v);
            chk(v, wexp[c]);
            wr(ra(2'(c), OFS_CTRL), 32'h0);
        end
        $display("test registers done");
        setup(2'h0, 32'h100, 32'h200, 32'h2, cw(2'h1, 2'h1, RS_AUTO, SZ_LONG, 1'b0, 1'b1));
        waitv();
        chk(xfer.src, 32'h100);
        @(posedge i_ref_clk);
        #1 chk(32'(ack), 32'h1);
        waitu(2);
        rd(ra(2'h0, OFS_SRC), v);
        chk(v, 32'h108);
        rd(ra(2'h0, OFS_DST), v);
        chk(v, 32'h208);
        rd(ra(2'h0, OFS_CNT), v);
        chk(v, 32'h0);
        chk(32'(irq), 32'h1);
        wr(OFS_GLOBAL, 32'h1);
        wr(ra(2'h0, OFS_CTRL), 32'h0);
        rd(ra(2'h0, OFS_CTRL), v);
        chk(v, 32'h2);
        clr(2'h0);
        rd(ra(2'h0, OFS_CTRL), v);
        chk(v, 32'h0);
        $display("test auto cycle steal done");
        for (int s = 0; s < 3; s++)
            for (int m = 0; m < 3; m++)
            begin
                setup(2'h1, 32'h800, 32'h1000, 32'h1,
                    cw(2'(m), 2'((3 - m) % 3), RS_AUTO, 2'(s), 1'b1, 1'(m == 1)));
                waitu(1);
                rd(ra(2'h1, OFS_DST), v);
                chk(v, 32'h1000 + dlt(2'(m), 2'(s)));
                rd(ra(2'h1, OFS_SRC), v);
                chk(v, 32'h800 + dlt(2'((3 - m) % 3), 2'(s)));
                chk(32'(irq[1]), 32'(m == 1));
                clr(2'h1);
            end
        $display("test stepping done");
        // source holds the pointer location, not the data address
        setup(2'h3, 32'h2000, 32'h3000, 32'h1,
            cw(2'h0, 2'h1, RS_AUTO, 2'h0, 1'b0, 1'b1) | 32'h0010_0000);
        waitv();
        chk(32'(xfer.indirect), 32'h1);
        waitu(1);
        rd(ra(2'h3, OFS_SRC), v);
        chk(v, 32'h2004);
        clr(2'h3);
        setup(2'h0, 32'h400, 32'h500, 32'h1, cw(2'h1, 2'h1, RS_EXT_D2M, 2'h1, 1'b0, 1'b1));
        req_n <= 2'b10;
        waitv();
        chk({30'h0, xfer.single, xfer.dev2mem}, 32'h3);
        waitu(1);
        req_n <= 2'b11;
        rd(ra(2'h0, OFS_DST), v);
        chk(v, 32'h500);
        clr(2'h0);
        $display("test indirect and single done");
        // pin already low at enable: edge sampling must not start
        req_n <= 2'b01;
        setup(2'h1, 32'h0, 32'h0, 32'h1,
            cw(2'h0, 2'h0, RS_EXT_DUAL, 2'h0, 1'b0, 1'b1) | 32'h0001_0040);
        repeat (8) @(posedge i_ref_clk);
        req_n <= 2'b11;
        #1 chk(32'(units - mark), 32'h0);
        chk(32'(ack), 32'h2);
        repeat (2) @(posedge i_ref_clk);
        req_n <= 2'b01;
        waitv();
        @(posedge i_ref_clk);
        #1 chk(32'(ack), 32'h0);
        waitu(1);
        req_n <= 2'b11;
        clr(2'h1);
        for (int k = 0; k < NPER; k++)
        begin
            setup(2'h2, 32'h0, 32'h0, 32'h1,
                cw(2'h0, 2'h0, RS_PER_FIRST + 4'(k), 2'h0, 1'b0, 1'b1));
            preq[(k + 1) % NPER] <= 1'b1;
            @(posedge i_ref_clk);
            preq <= '0;
            repeat (6) @(posedge i_ref_clk);
            chk(32'(units - mark), 32'h0);
            preq[k] <= 1'b1;
            @(posedge i_ref_clk);
            preq <= '0;
            waitu(1);
            clr(2'h2);
        end
        $display("test requests done");
        lat <= 4'hF;
        for (int k = 0; k < 3; k++)
        begin
            setup(2'h0, 32'h100, 32'h200, 32'h3, cw(2'h1, 2'h1, RS_AUTO, 2'h0, 1'b0, 1'b1));
            waitv();
            @(posedge i_ref_clk);
            if (k == 0)
                wr(ra(2'h0, OFS_CTRL), 32'h0);
            else if (k == 1)
                nmi <= 1'b1;
            else
                aerr <= 1'b1;
            @(posedge i_ref_clk);
            nmi <= 1'b0;
            aerr <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            chk(32'(units - mark), 32'h0);
            rd(ra(2'h0, OFS_CNT), v);
            chk(v, 32'h3);
            rd(ra(2'h0, OFS_CTRL), v);
            chk(v & 32'h2, 32'h0);
            rd(OFS_GLOBAL, v);
            chk(v, gexp[k]);
            wr(OFS_GLOBAL, 32'h0);
            wr(ra(2'h0, OFS_CTRL), 32'h0);
        end
        $display("test aborts done");
        lat <= 4'h1;
        setup(2'h0, 32'h0, 32'h0, 32'h1, cw(2'h0, 2'h0, RS_AUTO, 2'h0, 1'b0, 1'b1));
        waitu(1);
        stby <= 1'b1;
        @(posedge i_ref_clk);
        stby <= 1'b0;
        rd(ra(2'h0, OFS_CTRL), v);
        chk(v, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test standby done");
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
